// file: src/pvs_pkg.sv
package pvs_pkg;

  localparam int unsigned ADDR_W = 16;
  localparam int unsigned DATA_W = 16;

  // register offsets
  localparam logic [15:0] OFS_PAIR_B_SKEW = 16'h0091;
  localparam logic [15:0] OFS_PAIR_CD_SKEW = 16'h0092;
  localparam logic [15:0] OFS_RETRAIN = 16'h0093;
  localparam logic [15:0] OFS_LDR_CTRL = 16'hA817;
  localparam logic [15:0] OFS_LDR_STAT = 16'hA818;
  localparam logic [15:0] OFS_LDR_ADDR_LO = 16'hA819;
  localparam logic [15:0] OFS_LDR_ADDR_HI = 16'hA81A;
  localparam logic [15:0] OFS_LDR_WORD_LO = 16'hA81B;
  localparam logic [15:0] OFS_LDR_WORD_HI = 16'hA81C;
  localparam logic [15:0] OFS_LAMP1_EN_LO = 16'hA82C;
  localparam logic [15:0] OFS_LAMP1_FLASH = 16'hA82E;
  localparam logic [15:0] OFS_LAMP2_EN_LO = 16'hA82F;
  localparam logic [15:0] OFS_LAMP2_FLASH = 16'hA831;
  localparam logic [15:0] OFS_LAMP1_EN_EXT = 16'hA8EF;
  localparam logic [15:0] OFS_LAMP2_EN_EXT = 16'hA8F0;

  // field positions
  localparam int unsigned SKEW_W = 7;
  localparam int unsigned SKEW_HI_LSB = 8;
  localparam int unsigned SKEW_LO_LSB = 0;
  localparam int unsigned PEER_CNT_LSB = 11;
  localparam int unsigned LOCAL_CNT_LSB = 6;
  localparam int unsigned RT_CNT_W = 5;
  localparam int unsigned SUPPORTED_BIT = 4;
  localparam int unsigned AGREED_BIT = 3;
  localparam int unsigned SIGSEL_LSB = 1;
  localparam int unsigned ENABLE_BIT = 0;
  localparam int unsigned DONE_BIT = 0;
  localparam int unsigned FLASH_W = 4;

  // reset values and limits
  localparam logic [15:0] LDR_RESET = 16'h0000;
  localparam logic [15:0] EN_RESET = 16'h0000;
  localparam logic [15:0] FLASH_RESET = 16'h0004;
  localparam logic [4:0] RT_CNT_MAX = 5'h1F;
  localparam logic [6:0] SKEW_MAX_CODE = 7'h3F;
  localparam logic [6:0] SKEW_MIN_CODE = 7'h40;

  // timing
  localparam longint unsigned CLK_PERIOD_PS = 100000;
  localparam longint unsigned SKEW_REFRESH_MS = 1000;
  localparam longint unsigned SKEW_REFRESH_CYC =
    (SKEW_REFRESH_MS * 64'd1000000000) / CLK_PERIOD_PS;
  localparam longint unsigned BASE_TICK_PS = 10000;
  localparam logic [7:0] BASE_PER_CLK = 8'(CLK_PERIOD_PS / BASE_TICK_PS);

  typedef enum logic [1:0] {
    PVS_SIG_IDLE,
    PVS_SIG_LOCAL_FAULT,
    PVS_SIG_LINK_INT,
    PVS_SIG_RSVD
  } pvs_sigsel_t;

  typedef struct packed {
    logic [ADDR_W-1:0] addr;
    logic [DATA_W-1:0] wdata;
    logic wr;
    logic rd;
  } pvs_req_t;

  typedef struct packed {
    logic [DATA_W-1:0] ctrl;
    logic [31:0] addr;
    logic [31:0] word;
  } pvs_loader_t;

endpackage

// file: src/pvs_regs.sv
`timescale 1ns/1ps
// Operation
// - pair B skew, 7-bit signed, bits 14:8, 1.25 ns per step
// - positive skew code means delay, negative means advance versus pair A
// - skew beyond -80..+78.75 ns clamps to extreme code, never wraps
// - every skew field refreshed at least once per second
// - second skew word: pair D at 14:8, pair C at 6:0, 15 and 7 zero
// - peer retrain counter at 15:11 counts up, holds at 31
// - local retrain counter at 10:6 counts up, holds at 31
// - reading retrain word returns counts then clears both counters
// - bit 4 retrain supported, bit 3 retrain agreed, both 0 after reset
// - bits 2:1 select idle, local fault or link interruption to MAC
// - bit 0 enables quick retrain, initial value loaded by firmware
// - done bit 0 set when load finishes; controller polls until set
// - 16-bit loader control word, read-write, resets to zero
// - loader address and data high/low words, read-write, reset zero
// - per lamp low mask enables sources 0 to 15, reset zero
// - per lamp extended mask enables sources 32 to 47, reset zero
// - per lamp 4-bit flash count, reset 4, slow ticks on and off
// - slow tick period is (hi:lo + 1) times 10 ns
module pvs_regs
  import pvs_pkg::*;
#(
  parameter int unsigned SKEW_IN_W = 10,
  parameter longint unsigned REFRESH_CYCLES = SKEW_REFRESH_CYC,
  parameter int unsigned LAMPS = 2
) (
  input wire logic clk,
  input wire logic srst,
  input wire pvs_req_t reg_req,
  output logic [DATA_W-1:0] reg_rdata,
  output logic reg_rvalid,
  input wire logic signed [SKEW_IN_W-1:0] pair_b_meas,
  input wire logic signed [SKEW_IN_W-1:0] pair_c_meas,
  input wire logic signed [SKEW_IN_W-1:0] pair_d_meas,
  input wire logic peer_retrain_evt,
  input wire logic local_retrain_evt,
  input wire logic quick_retrain_supported,
  input wire logic quick_retrain_agreed,
  input wire logic fw_enable_load,
  input wire logic fw_enable_value,
  output pvs_sigsel_t retrain_mac_signal_sel,
  output logic quick_retrain_enable,
  input wire logic loader_done,
  output pvs_loader_t loader_out,
  input wire logic [7:0] lamp_tick_divider_hi,
  input wire logic [15:0] lamp_tick_divider_lo,
  input wire logic [15:0] lamp_src_lo,
  input wire logic [15:0] lamp_src_ext,
  input wire logic [LAMPS-1:0] lamp_blink_mode,
  output logic [LAMPS-1:0] lamp_out
);

  if (SKEW_IN_W < SKEW_W || SKEW_IN_W > 30 || LAMPS != 2 || REFRESH_CYCLES < 2) begin : g_bad_cfg
    $error("pvs_regs: unsupported parameter");
  end

  function automatic logic [6:0] clamp_skew(input logic signed [SKEW_IN_W-1:0] m);
    logic signed [SKEW_IN_W-1:0] hi;
    logic signed [SKEW_IN_W-1:0] lo;
    hi = SKEW_IN_W'(63);
    lo = -SKEW_IN_W'(64);
    if (m > hi) begin
      clamp_skew = SKEW_MAX_CODE;
    end else if (m < lo) begin
      clamp_skew = SKEW_MIN_CODE;
    end else begin
      clamp_skew = m[6:0];
    end
  endfunction

  // decode
  wire wr = reg_req.wr;
  wire rd = reg_req.rd;
  wire [15:0] a = reg_req.addr;
  wire [15:0] wd = reg_req.wdata;
  wire wr_rt = wr && a == OFS_RETRAIN;
  wire rd_rt = rd && a == OFS_RETRAIN;
  wire wr_ctrl = wr && a == OFS_LDR_CTRL;

  // skew refresh
  logic [31:0] refresh_cnt_r;
  logic [6:0] pair_b_lag_r;
  logic [6:0] pair_c_lag_r;
  logic [6:0] pair_d_lag_r;
  wire refresh_tick = refresh_cnt_r == 32'(REFRESH_CYCLES - 1);

  always_ff @(posedge clk) begin
    if (srst || refresh_tick) begin
      refresh_cnt_r <= 32'h0;
    end else begin
      refresh_cnt_r <= refresh_cnt_r + 32'h1;
    end
  end

  always_ff @(posedge clk) begin
    if (srst) begin
      pair_b_lag_r <= 7'h0;
      pair_c_lag_r <= 7'h0;
      pair_d_lag_r <= 7'h0;
    end else if (refresh_tick) begin
      pair_b_lag_r <= clamp_skew(pair_b_meas);
      pair_c_lag_r <= clamp_skew(pair_c_meas);
      pair_d_lag_r <= clamp_skew(pair_d_meas);
    end
  end

  // retrain counters
  logic [4:0] peer_retrain_count_r;
  logic [4:0] local_retrain_count_r;
  logic [4:0] peer_nxt;
  logic [4:0] local_nxt;
  logic supported_r;
  logic agreed_r;

  always_comb begin
    peer_nxt = rd_rt ? 5'h0 : peer_retrain_count_r;
    local_nxt = rd_rt ? 5'h0 : local_retrain_count_r;
    if (peer_retrain_evt && peer_nxt != RT_CNT_MAX) begin
      peer_nxt = peer_nxt + 5'h1;
    end
    if (local_retrain_evt && local_nxt != RT_CNT_MAX) begin
      local_nxt = local_nxt + 5'h1;
    end
  end

  always_ff @(posedge clk) begin
    if (srst) begin
      peer_retrain_count_r <= 5'h0;
      local_retrain_count_r <= 5'h0;
      supported_r <= 1'b0;
      agreed_r <= 1'b0;
      retrain_mac_signal_sel <= PVS_SIG_IDLE;
      quick_retrain_enable <= EN_RESET[0];
    end else begin
      peer_retrain_count_r <= peer_nxt;
      local_retrain_count_r <= local_nxt;
      supported_r <= quick_retrain_supported;
      agreed_r <= quick_retrain_agreed;
      if (wr_rt) begin
        retrain_mac_signal_sel <= pvs_sigsel_t'(wd[SIGSEL_LSB +: 2]);
        quick_retrain_enable <= wd[ENABLE_BIT];
      end else if (fw_enable_load) begin
        quick_retrain_enable <= fw_enable_value;
      end
    end
  end

  // loader words
  logic done_r;

  always_ff @(posedge clk) begin
    if (srst) begin
      loader_out <= '0;
      done_r <= 1'b0;
    end else begin
      if (wr_ctrl) begin
        loader_out.ctrl <= wd;
      end
      if (wr && a == OFS_LDR_ADDR_LO) begin
        loader_out.addr[15:0] <= wd;
      end
      if (wr && a == OFS_LDR_ADDR_HI) begin
        loader_out.addr[31:16] <= wd;
      end
      if (wr && a == OFS_LDR_WORD_LO) begin
        loader_out.word[15:0] <= wd;
      end
      if (wr && a == OFS_LDR_WORD_HI) begin
        loader_out.word[31:16] <= wd;
      end
      // new command clears done; a finish in the same cycle wins
      if (loader_done) begin
        done_r <= 1'b1;
      end else if (wr_ctrl) begin
        done_r <= 1'b0;
      end
    end
  end

  // slow tick from 10 ns base units
  logic [24:0] base_acc_r;
  wire [24:0] tick_len = {1'b0, lamp_tick_divider_hi, lamp_tick_divider_lo} + 25'h1;
  wire [24:0] acc_sum = base_acc_r + 25'(BASE_PER_CLK);
  wire slow_tick = acc_sum >= tick_len;

  always_ff @(posedge clk) begin
    if (srst) begin
      base_acc_r <= 25'h0;
    end else if (slow_tick) begin
      base_acc_r <= acc_sum - tick_len;
    end else begin
      base_acc_r <= acc_sum;
    end
  end

  // lamps
  logic [15:0] en_lo_r [LAMPS];
  logic [15:0] en_ext_r [LAMPS];
  logic [15:0] flash_r [LAMPS];
  logic [FLASH_W-1:0] phase_cnt_r [LAMPS];
  logic [LAMPS-1:0] phase_on_r;
  logic [15:0] ofs_en_lo [LAMPS];
  logic [15:0] ofs_en_ext [LAMPS];
  logic [15:0] ofs_flash [LAMPS];
  assign ofs_en_lo[0] = OFS_LAMP1_EN_LO;
  assign ofs_en_lo[1] = OFS_LAMP2_EN_LO;
  assign ofs_en_ext[0] = OFS_LAMP1_EN_EXT;
  assign ofs_en_ext[1] = OFS_LAMP2_EN_EXT;
  assign ofs_flash[0] = OFS_LAMP1_FLASH;
  assign ofs_flash[1] = OFS_LAMP2_FLASH;

  for (genvar i = 0; i < LAMPS; i++) begin : g_lamp
    wire lit = |(lamp_src_lo & en_lo_r[i]) || |(lamp_src_ext & en_ext_r[i]);
    wire [FLASH_W-1:0] lamp_flash_count = flash_r[i][FLASH_W-1:0];
    wire phase_end = phase_cnt_r[i] + 4'h1 >= lamp_flash_count;

    always_ff @(posedge clk) begin
      if (srst) begin
        en_lo_r[i] <= EN_RESET;
        en_ext_r[i] <= EN_RESET;
        flash_r[i] <= FLASH_RESET;
      end else if (wr) begin
        if (a == ofs_en_lo[i]) begin
          en_lo_r[i] <= wd;
        end
        if (a == ofs_en_ext[i]) begin
          en_ext_r[i] <= wd;
        end
        if (a == ofs_flash[i]) begin
          flash_r[i] <= wd;
        end
      end
    end

    always_ff @(posedge clk) begin
      if (srst) begin
        phase_cnt_r[i] <= 4'h0;
        phase_on_r[i] <= 1'b1;
      end else if (slow_tick) begin
        if (phase_end) begin
          phase_cnt_r[i] <= 4'h0;
          phase_on_r[i] <= !phase_on_r[i];
        end else begin
          phase_cnt_r[i] <= phase_cnt_r[i] + 4'h1;
        end
      end
    end

    always_ff @(posedge clk) begin
      if (srst) begin
        lamp_out[i] <= 1'b0;
      end else begin
        lamp_out[i] <= lit && (!lamp_blink_mode[i] || phase_on_r[i]);
      end
    end
  end

  // read mux
  logic [15:0] rd_mux;

  always_comb begin
    rd_mux = 16'h0;
    unique case (a)
      OFS_PAIR_B_SKEW: rd_mux = {1'b0, pair_b_lag_r, 8'h00};
      OFS_PAIR_CD_SKEW: rd_mux = {1'b0, pair_d_lag_r, 1'b0, pair_c_lag_r};
      OFS_RETRAIN: rd_mux = {peer_retrain_count_r, local_retrain_count_r, 1'b0,
        supported_r, agreed_r, retrain_mac_signal_sel, quick_retrain_enable};
      OFS_LDR_CTRL: rd_mux = loader_out.ctrl;
      OFS_LDR_STAT: rd_mux = {15'h0000, done_r};
      OFS_LDR_ADDR_LO: rd_mux = loader_out.addr[15:0];
      OFS_LDR_ADDR_HI: rd_mux = loader_out.addr[31:16];
      OFS_LDR_WORD_LO: rd_mux = loader_out.word[15:0];
      OFS_LDR_WORD_HI: rd_mux = loader_out.word[31:16];
      OFS_LAMP1_EN_LO: rd_mux = en_lo_r[0];
      OFS_LAMP2_EN_LO: rd_mux = en_lo_r[1];
      OFS_LAMP1_EN_EXT: rd_mux = en_ext_r[0];
      OFS_LAMP2_EN_EXT: rd_mux = en_ext_r[1];
      OFS_LAMP1_FLASH: rd_mux = flash_r[0];
      OFS_LAMP2_FLASH: rd_mux = flash_r[1];
      default: rd_mux = 16'h0;
    endcase
  end

  always_ff @(posedge clk) begin
    if (srst) begin
      reg_rdata <= 16'h0;
      reg_rvalid <= 1'b0;
    end else begin
      reg_rvalid <= rd;
      if (rd) begin
        reg_rdata <= rd_mux;
      end
    end
  end

  // checks
  default clocking cb @(posedge clk); endclocking
  default disable iff (srst);

  sequence s_rt_read;
    rd_rt && !peer_retrain_evt && !local_retrain_evt;
  endsequence

  sequence s_counts_zero;
    peer_retrain_count_r == 5'h0 && local_retrain_count_r == 5'h0;
  endsequence

  a_read_clears_counts: assert property (s_rt_read |=> s_counts_zero)
    else $error("retrain counters not cleared by read");
  a_read_returns_old: assert property (rd_rt |=> reg_rvalid &&
    reg_rdata[15:11] == $past(peer_retrain_count_r))
    else $error("retrain read lost the count");
  a_peer_saturates: assert property (peer_retrain_count_r == RT_CNT_MAX && !rd_rt
    |=> peer_retrain_count_r == RT_CNT_MAX)
    else $error("peer counter wrapped");
  a_local_counts_up: assert property (local_retrain_evt && !rd_rt &&
    local_retrain_count_r != RT_CNT_MAX
    |=> local_retrain_count_r == $past(local_retrain_count_r) + 5'h1)
    else $error("local counter missed event");
  a_skew_clamp_high: assert property (refresh_tick && pair_b_meas > SKEW_IN_W'(63)
    |=> pair_b_lag_r == SKEW_MAX_CODE)
    else $error("skew high not clamped");
  a_skew_clamp_low: assert property (refresh_tick && pair_d_meas < -SKEW_IN_W'(64)
    |=> pair_d_lag_r == SKEW_MIN_CODE)
    else $error("skew low not clamped");
  a_skew_held_between: assert property (!refresh_tick |=> $stable(pair_c_lag_r))
    else $error("skew changed without refresh");
  a_done_sets: assert property (loader_done |=> done_r ##1 (done_r || $past(wr_ctrl)))
    else $error("done bit not set");
  a_sigsel_write: assert property (wr_rt |=> retrain_mac_signal_sel ==
    pvs_sigsel_t'($past(wd[2:1])))
    else $error("signal select not written");
  a_lamp_dark_masked: assert property (en_lo_r[0] == 16'h0 && en_ext_r[0] == 16'h0
    |=> !lamp_out[0])
    else $error("lamp lit with no source enabled");
  a_flash_reset_four: assert property (disable iff (1'b0)
    srst |=> flash_r[1] == FLASH_RESET)
    else $error("flash count reset wrong");

endmodule

// file: verif/pvs_mgmt_model.sv
`timescale 1ns/1ps
// station controller: one request per edge, then released bus
module pvs_mgmt_model
  import pvs_pkg::*;
(
  input wire logic clk,
  output pvs_req_t reg_req,
  input wire logic [DATA_W-1:0] reg_rdata,
  input wire logic reg_rvalid
);
  initial begin
    reg_req = '0;
  end
  task automatic wr(input logic [15:0] a, input logic [15:0] d);
    @(posedge clk);
    reg_req <= '{addr: a, wdata: d, wr: 1'b1, rd: 1'b0};
    @(posedge clk);
    reg_req <= '{addr: ~a, wdata: ~d, wr: 1'b0, rd: 1'b0};
  endtask
  task automatic rd(input logic [15:0] a, output logic [15:0] d);
    int n;
    n = 0;
    d = 16'hXXXX;
    @(posedge clk);
    reg_req <= '{addr: a, wdata: 16'h5A5A, wr: 1'b0, rd: 1'b1};
    @(posedge clk);
    reg_req <= '{addr: ~a, wdata: 16'hA5A5, wr: 1'b0, rd: 1'b0};
    #1;
    while (reg_rvalid !== 1'b1 && n < 4) begin
      @(posedge clk);
      #1;
      n++;
    end
    if (reg_rvalid === 1'b1) d = reg_rdata;
  endtask
  // wait while done reads 0
  task automatic poll_done(output logic ok);
    logic [15:0] s;
    ok = 1'b0;
    for (int i = 0; i < 20 && !ok; i++) begin
      rd(OFS_LDR_STAT, s);
      ok = (s[DONE_BIT] === 1'b1);
    end
  endtask
  // reserved flash bits kept by read-modify-write
  task automatic set_flash(input logic [15:0] a, input logic [3:0] c);
    logic [15:0] s;
    rd(a, s);
    wr(a, {s[15:4], c});
  endtask
endmodule

// file: verif/pvs_regs_bench.sv
`timescale 1ns/1ps
module pvs_regs_bench
  import pvs_pkg::*;
;
  localparam int RC = 20;
  logic clk, srst, pk, lk, sup, agr, fwl, fwv, ldone;
  logic signed [9:0] mb, mc, md;
  logic [15:0] slo, sext, d;
  pvs_req_t req;
  logic [15:0] rdata;
  logic rvalid, en;
  pvs_sigsel_t sel;
  pvs_loader_t lout;
  logic [1:0] lamp, bm;
  int mismatches, n_compared;
  localparam logic [15:0] RWA [9] = '{OFS_LDR_CTRL, OFS_LDR_ADDR_LO, OFS_LDR_ADDR_HI,
    OFS_LDR_WORD_LO, OFS_LDR_WORD_HI, OFS_LAMP1_EN_LO, OFS_LAMP2_EN_LO,
    OFS_LAMP1_EN_EXT, OFS_LAMP2_EN_EXT};
  pvs_regs #(.REFRESH_CYCLES(RC)) dut (.clk(clk), .srst(srst), .reg_req(req),
    .reg_rdata(rdata), .reg_rvalid(rvalid), .pair_b_meas(mb), .pair_c_meas(mc),
    .pair_d_meas(md), .peer_retrain_evt(pk), .local_retrain_evt(lk),
    .quick_retrain_supported(sup), .quick_retrain_agreed(agr), .fw_enable_load(fwl),
    .fw_enable_value(fwv), .retrain_mac_signal_sel(sel), .quick_retrain_enable(en),
    .loader_done(ldone), .loader_out(lout), .lamp_tick_divider_hi(8'h00),
    .lamp_tick_divider_lo(16'h0013), .lamp_src_lo(slo), .lamp_src_ext(sext),
    .lamp_blink_mode(bm), .lamp_out(lamp));
  pvs_mgmt_model mgmt (.clk(clk), .reg_req(req), .reg_rdata(rdata), .reg_rvalid(rvalid));
  initial begin
    clk = 1'b0;
    forever #50 clk = ~clk;
  end
  task automatic chk(input logic [79:0] g, input logic [79:0] e);
    n_compared++;
    if (g !== e) begin
      mismatches++;
      $display("MISMATCH t=%0t got=%h exp=%h", $time, g, e);
    end
  endtask
  task automatic rdchk(input logic [15:0] a, input logic [15:0] e);
    mgmt.rd(a, d);
    chk(d, e);
  endtask
  task automatic t_reset();
    foreach (RWA[i]) rdchk(RWA[i], 16'h0000);
    rdchk(OFS_LAMP1_FLASH, 16'h0004);
    rdchk(OFS_LAMP2_FLASH, 16'h0004);
    rdchk(OFS_RETRAIN, 16'h0000);
    rdchk(OFS_LDR_STAT, 16'h0000);
    rdchk(16'h0094, 16'h0000);
  endtask
  task automatic t_rw();
    foreach (RWA[i]) mgmt.wr(RWA[i], 16'hA5C3 ^ 16'(i * 16'h1111));
    foreach (RWA[i]) rdchk(RWA[i], 16'hA5C3 ^ 16'(i * 16'h1111));
    chk(lout, {16'hA5C3, 16'h87E1, 16'hB4D2, 16'hE187, 16'h96F0});
    mgmt.wr(OFS_PAIR_CD_SKEW, 16'h1234);
    rdchk(OFS_PAIR_CD_SKEW, 16'h0000);
  endtask
  task automatic t_retrain();
    @(posedge clk);
    pk <= 1'b1;
    lk <= 1'b1;
    sup <= 1'b1;
    agr <= 1'b1;
    repeat (3) @(posedge clk);
    lk <= 1'b0;
    repeat (30) @(posedge clk);
    pk <= 1'b0;
    rdchk(OFS_RETRAIN, {5'd31, 5'd3, 6'h18});
    rdchk(OFS_RETRAIN, 16'h0018);
    for (int k = 0; k < 3; k++) begin
      mgmt.wr(OFS_RETRAIN, 16'(2 * k + 1));
      #1;
      chk(sel, 80'(k));
      chk(en, 1'b1);
      rdchk(OFS_RETRAIN, 16'(2 * k + 25));
    end
    @(posedge clk);
    fwv <= 1'b0;
    fwl <= 1'b1;
    @(posedge clk);
    fwl <= 1'b0;
    @(posedge clk);
    chk(en, 1'b0);
  endtask
  task automatic t_skew();
    @(posedge clk);
    mb <= 10'sd100;
    mc <= -10'sd5;
    md <= -10'sd100;
    repeat (2 * RC + 2) @(posedge clk);
    rdchk(OFS_PAIR_B_SKEW, 16'h3F00);
    rdchk(OFS_PAIR_CD_SKEW, 16'h407B);
    @(posedge clk);
    mb <= -10'sd3;
    md <= 10'sd64;
    repeat (RC + 2) @(posedge clk);
    rdchk(OFS_PAIR_B_SKEW, 16'h7D00);
    rdchk(OFS_PAIR_CD_SKEW, 16'h3F7B);
  endtask
  task automatic t_loader();
    logic ok;
    fork
      begin
        repeat (12) @(posedge clk);
        ldone <= 1'b1;
        @(posedge clk);
        ldone <= 1'b0;
      end
      mgmt.poll_done(ok);
    join
    chk(ok, 1'b1);
    mgmt.wr(OFS_LDR_CTRL, 16'h0000);
    rdchk(OFS_LDR_STAT, 16'h0000);
  endtask
  task automatic t_lamp();
    int n;
    mgmt.wr(OFS_LAMP1_EN_LO, 16'h0020);
    mgmt.wr(OFS_LAMP2_EN_EXT, 16'h0004);
    mgmt.wr(OFS_LAMP1_EN_EXT, 16'h0000);
    mgmt.wr(OFS_LAMP2_EN_LO, 16'h0000);
    @(posedge clk);
    slo <= 16'hFFDF;
    sext <= 16'hFFFB;
    repeat (3) @(posedge clk);
    chk(lamp, 2'b00);
    slo <= 16'h0020;
    sext <= 16'h0004;
    repeat (3) @(posedge clk);
    chk(lamp, 2'b11);
    mgmt.wr(OFS_LAMP1_FLASH, 16'hABC9);
    rdchk(OFS_LAMP1_FLASH, 16'hABC9);
    mgmt.set_flash(OFS_LAMP1_FLASH, 4'h2);
    rdchk(OFS_LAMP1_FLASH, 16'hABC2);
    // lamp 1 flashes: 2 slow ticks of 200 ns each = 4 clocks on
    @(posedge clk);
    bm <= 2'b01;
    n = 0;
    while (lamp[0] !== 1'b0 && n < 20) begin
      @(posedge clk);
      n++;
    end
    while (lamp[0] !== 1'b1 && n < 40) begin
      @(posedge clk);
      n++;
    end
    n = 0;
    while (lamp[0] === 1'b1 && n < 20) begin
      @(posedge clk);
      n++;
    end
    chk(n, 4);
    chk(lamp[1], 1'b1);
  endtask
  task automatic print_verdict();
    $display("compared %0d mismatches %0d", n_compared, mismatches);
    if (mismatches == 0 && n_compared > 0) begin
      $display("== PASSED ==");
    end else begin
      $display("== FAILED ==");
    end
    $finish;
  endtask
  initial begin
    #3000000;
    mismatches++;
    print_verdict();
  end
  initial begin
    mismatches = 0;
    n_compared = 0;
    {srst, pk, lk, sup, agr, fwl, fwv, ldone} = 8'h80;
    bm = 2'b00;
    {mb, mc, md} = '0;
    slo = '0;
    sext = '0;
    repeat (3) @(posedge clk);
    srst <= 1'b0;
    t_reset();
    t_rw();
    t_retrain();
    t_skew();
    t_loader();
    t_lamp();
    print_verdict();
  end
endmodule
